// ### common/alarm_flag_regs.vh
`ifndef ALARM_FLAG_REGS_VH
`define ALARM_FLAG_REGS_VH

// Program register addresses of the alarm flag bank.
`define ADDR_WIDTH          7
`define ADDR_OVERVIEW       7'h10
`define ADDR_LOW_TRIPPED    7'h11
`define ADDR_LOW_ACTIVE     7'h12
`define ADDR_HIGH_TRIPPED   7'h13
`define ADDR_HIGH_ACTIVE    7'h14

// Register width, reset value and the pattern for missing bits.
`define REG_WIDTH           8
`define REG_RESET           8'h00
`define REG_ABSENT          8'hFF
`define FLAG_RESET          1'b0

// Channels held in each per-channel flag register.
`define CH_PER_REG          4

// Widths of the comparison settings.
`define SAMPLE_WIDTH        16
`define HYST_WIDTH          8
`define CH_INDEX_WIDTH      3

// Reset synchroniser value while in reset.
`define SYNC_RESET          2'b00

`endif

// ### rtl/alarm_threshold_compare.v
`include "alarm_flag_regs.vh"

// One channel's high and low comparison with a shared hysteresis band.
module alarm_threshold_compare (
   input  wire                       clock,
   input  wire                       rst_n,
   input  wire                       sample_valid,
   input  wire [`SAMPLE_WIDTH-1:0]   sample,
   input  wire [`SAMPLE_WIDTH-1:0]   high_threshold,
   input  wire [`SAMPLE_WIDTH-1:0]   low_threshold,
   input  wire [`HYST_WIDTH-1:0]     hysteresis,
   output reg                        high_active,
   output reg                        low_active
);

   wire [`SAMPLE_WIDTH:0] sample_ext;
   wire [`SAMPLE_WIDTH:0] high_release;
   wire [`SAMPLE_WIDTH:0] low_release;

   // Release points are computed one bit wider; a high release that wraps below zero shows in the top bit.
   assign sample_ext   = {1'b0, sample};
   assign high_release = {1'b0, high_threshold} - {{(`SAMPLE_WIDTH-`HYST_WIDTH+1){1'b0}}, hysteresis};
   assign low_release  = {1'b0, low_threshold} + {{(`SAMPLE_WIDTH-`HYST_WIDTH+1){1'b0}}, hysteresis};

   // A flag sets past its threshold and clears once back beyond the band.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         high_active <= `FLAG_RESET;
         low_active  <= `FLAG_RESET;
      end else if (sample_valid) begin
         if (sample > high_threshold)
            high_active <= 1'b1;
         else if (high_release[`SAMPLE_WIDTH] || sample_ext < high_release)
            high_active <= 1'b0;
         if (sample < low_threshold)
            low_active <= 1'b1;
         else if (sample_ext > low_release)
            low_active <= 1'b0;
      end
   end

endmodule

// ### rtl/alarm_flag_registers.v
`include "alarm_flag_regs.vh"

module alarm_flag_registers #(
   parameter NUM_CHANNELS = 8
) (
   input  wire                                 clock,
   input  wire                                 arst_n,
   input  wire                                 sample_valid,
   input  wire [`CH_INDEX_WIDTH-1:0]           sample_channel,
   input  wire [`SAMPLE_WIDTH-1:0]             sample,
   input  wire [8*`SAMPLE_WIDTH-1:0]           high_thresholds,
   input  wire [8*`SAMPLE_WIDTH-1:0]           low_thresholds,
   input  wire [8*`HYST_WIDTH-1:0]             hysteresis,
   input  wire                                 rd_strobe,
   input  wire                                 wr_strobe,
   input  wire [`ADDR_WIDTH-1:0]               reg_addr,
   output reg  [`REG_WIDTH-1:0]                rd_data,
   output reg                                  rd_valid,
   output reg                                  rd_hit,
   output reg                                  wr_ack,
   output reg                                  alarm
);

   reg  [1:0]  reset_sync;
   wire        rst_n;
   wire [7:0]  high_active;
   wire [7:0]  low_active;
   reg  [7:0]  high_tripped;
   reg  [7:0]  low_tripped;
   reg  [7:0]  next_high_tripped;
   reg  [7:0]  next_low_tripped;
   wire [7:0]  present;
   wire [7:0]  overview;
   reg  [`REG_WIDTH-1:0] next_rd_data;
   reg                   next_rd_hit;
   wire        clear_low_group;
   wire        clear_high_group;

   // Pack four channels from a base into low/high pairs, channel base in bits 7:6.
   function [`REG_WIDTH-1:0] pack_pairs;
      input [7:0] low_flags;
      input [7:0] high_flags;
      input [2:0] base;
      integer     c;
      reg   [2:0] ch;
      begin
         pack_pairs = `REG_RESET;
         for (c = 0; c < `CH_PER_REG; c = c + 1) begin
            ch = base + c[2:0];
            pack_pairs[7-2*c] = low_flags[ch];
            pack_pairs[6-2*c] = high_flags[ch];
         end
      end
   endfunction

   // Force the bits of channels that this build does not have to one.
   function [`REG_WIDTH-1:0] fill_absent;
      input [`REG_WIDTH-1:0] value;
      input [7:0]            exists;
      begin
         fill_absent = value | ~exists;
      end
   endfunction

   // Reset is released through two flip-flops.
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         reset_sync <= `SYNC_RESET;
      else
         reset_sync <= {reset_sync[0], 1'b1};
   end

   assign rst_n = reset_sync[1];

   // Channel presence mask for the build width.
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : channel
         if (g < NUM_CHANNELS) begin : real_ch
            assign present[g] = 1'b1;
            // Each channel has its own high and low comparison.
            alarm_threshold_compare compare (
               .clock          (clock),
               .rst_n          (rst_n),
               .sample_valid   (sample_valid && sample_channel == g),
               .sample         (sample),
               .high_threshold (high_thresholds[g*`SAMPLE_WIDTH +: `SAMPLE_WIDTH]),
               .low_threshold  (low_thresholds[g*`SAMPLE_WIDTH +: `SAMPLE_WIDTH]),
               .hysteresis     (hysteresis[g*`HYST_WIDTH +: `HYST_WIDTH]),
               .high_active    (high_active[g]),
               .low_active     (low_active[g])
            );
         end else begin : absent_ch
            // Missing channels hold no flag state at all.
            assign present[g]     = 1'b0;
            assign high_active[g] = `FLAG_RESET;
            assign low_active[g]  = `FLAG_RESET;
         end
      end
   endgenerate

   // A read of a tripped register clears its group after the data is taken.
   assign clear_low_group  = rd_strobe && reg_addr == `ADDR_LOW_TRIPPED;
   assign clear_high_group = rd_strobe && reg_addr == `ADDR_HIGH_TRIPPED;

   // Tripped flags: read clears, but a live condition sets again and wins.
   always @* begin
      next_low_tripped  = low_tripped;
      next_high_tripped = high_tripped;
      if (clear_low_group) begin
         next_low_tripped[3:0]  = 4'h0;
         next_high_tripped[3:0] = 4'h0;
      end
      if (clear_high_group) begin
         next_low_tripped[7:4]  = 4'h0;
         next_high_tripped[7:4] = 4'h0;
      end
      next_low_tripped  = (next_low_tripped | low_active) & present;
      next_high_tripped = (next_high_tripped | high_active) & present;
   end

   // Writes never reach the flag state; only live conditions and tripped-register reads change it.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         low_tripped  <= `REG_RESET;
         high_tripped <= `REG_RESET;
      end else begin
         low_tripped  <= next_low_tripped;
         high_tripped <= next_high_tripped;
      end
   end

   // Overview bit n is channel n's combined tripped status.
   assign overview = (low_tripped | high_tripped);

   // Read multiplexer over addresses 10h to 14h.
   always @* begin
      next_rd_data = `REG_RESET;
      next_rd_hit  = 1'b1;
      case (reg_addr)
         `ADDR_OVERVIEW:
            next_rd_data = fill_absent(overview, present);
         `ADDR_LOW_TRIPPED:
            next_rd_data = pack_pairs(low_tripped, high_tripped, 3'd0);
         `ADDR_LOW_ACTIVE:
            next_rd_data = pack_pairs(low_active, high_active, 3'd0);
         `ADDR_HIGH_TRIPPED:
            next_rd_data = (NUM_CHANNELS > `CH_PER_REG) ?
                           pack_pairs(low_tripped, high_tripped, 3'd4) :
                           `REG_ABSENT;
         `ADDR_HIGH_ACTIVE:
            next_rd_data = (NUM_CHANNELS > `CH_PER_REG) ?
                           pack_pairs(low_active, high_active, 3'd4) :
                           `REG_ABSENT;
         default: begin
            next_rd_data = `REG_RESET;
            next_rd_hit  = 1'b0;
         end
      endcase
   end

   // Read answer, write acknowledge and alarm indication are all registered.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data  <= `REG_RESET;
         rd_valid <= 1'b0;
         rd_hit   <= 1'b0;
         wr_ack   <= 1'b0;
         alarm    <= 1'b0;
      end else begin
         rd_valid <= rd_strobe;
         rd_hit   <= rd_strobe && next_rd_hit;
         if (rd_strobe)
            rd_data <= next_rd_data;
         wr_ack   <= wr_strobe && !rd_strobe;
         alarm    <= |(next_low_tripped | next_high_tripped);
      end
   end

endmodule

// ### verif/alarm_flag_checker_sva.sv
`include "alarm_flag_regs.vh"
// Port-level checks of the alarm flag bank.
module alarm_flag_checker #(
   parameter NUM_CHANNELS = 8
) (
   input wire         clock,
   input wire         arst_n,
   input wire         sample_valid,
   input wire [2:0]   sample_channel,
   input wire [15:0]  sample,
   input wire [127:0] high_thresholds,
   input wire [127:0] low_thresholds,
   input wire [63:0]  hysteresis,
   input wire         rd_strobe,
   input wire         wr_strobe,
   input wire [6:0]   reg_addr,
   input wire [7:0]   rd_data,
   input wire         rd_valid,
   input wire         rd_hit,
   input wire         wr_ack,
   input wire         alarm
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Addresses that belong to the flag bank.
   wire mapped = reg_addr >= `ADDR_OVERVIEW && reg_addr <= `ADDR_HIGH_ACTIVE;
   AST_RD_ANSWER: assert property (rd_strobe |=> rd_valid) else $error("read unanswered");
   AST_RD_NONE: assert property (!rd_strobe |=> !rd_valid && !rd_hit && $stable(rd_data))
      else $error("read answer without request");
   AST_UNMAPPED: assert property (rd_strobe && !mapped |=> !rd_hit && rd_data == 8'h00)
      else $error("unmapped read not refused");
   AST_HIT: assert property (rd_strobe && mapped |=> rd_hit)
      else $error("mapped read missed");
   AST_WR_ACK: assert property (wr_strobe && !rd_strobe |=> wr_ack) else $error("no write ack");
   AST_WR_SOLE: assert property (!wr_strobe |=> !wr_ack) else $error("stray write ack");
   AST_ALARM_LATCH: assert property (alarm && !rd_strobe |=> alarm) else $error("alarm lost");
   AST_ALARM_CAUSE: assert property ($rose(alarm) |-> $past(sample_valid, 2))
      else $error("alarm without sample");
   AST_OVERVIEW: assert property (rd_strobe && reg_addr == `ADDR_OVERVIEW && alarm |=>
      rd_data != 8'h00) else $error("overview empty during alarm");
   AST_ABSENT: assert property (rd_strobe && NUM_CHANNELS == 4 && reg_addr == 7'h13 |=>
      rd_data == 8'hFF) else $error("absent register not all ones");
endmodule
bind alarm_flag_registers alarm_flag_checker #(.NUM_CHANNELS(NUM_CHANNELS)) alarm_flag_checker_inst (
   .clock(clock), .arst_n(arst_n), .sample_valid(sample_valid), .sample_channel(sample_channel),
   .sample(sample), .high_thresholds(high_thresholds), .low_thresholds(low_thresholds),
   .hysteresis(hysteresis), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .reg_addr(reg_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit), .wr_ack(wr_ack), .alarm(alarm));

// ### verif/alarm_host_model.sv
// Serial host that reads and writes the flag bank one request at a time.
module alarm_host_model (
   input  wire        clock,
   input  wire [7:0]  rd_data,
   input  wire        rd_hit,
   input  wire        alarm,
   output logic       rd_strobe,
   output logic       wr_strobe,
   output logic [6:0] reg_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle address is scrambled so a stale value is never mistaken for a request.
   initial begin
      rd_strobe = 1'b0;
      wr_strobe = 1'b0;
      reg_addr = 7'h7F;
   end
   // One-cycle read; the answer is taken one edge after the request.
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h);
      @(posedge clock);
      #1 reg_addr = a;
      rd_strobe = 1'b1;
      @(posedge clock);
      #1 rd_strobe = 1'b0;
      reg_addr = ~a;
      d = rd_data;
      h = rd_hit;
   endtask
   // One-cycle write, which the bank must ignore.
   task automatic wr(input logic [6:0] a);
      @(posedge clock);
      #1 reg_addr = a;
      wr_strobe = 1'b1;
      @(posedge clock);
      #1 wr_strobe = 1'b0;
      reg_addr = ~a;
   endtask
   // Waits up to 20 clocks for the alarm pin to report an event.
   task automatic wait_alarm(output logic ok);
      ok = 1'b0;
      repeat (20) if (!ok) begin
         @(posedge clock);
         ok = (alarm === 1'b1);
      end
   endtask
endmodule

// ### verif/tb_top.sv
// Directed bench of the alarm flag bank, eight and four channel builds side by side.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 0, arst_n = 0, sample_valid = 0, rd_strobe, wr_strobe, rd_hit, alarm;
   logic [2:0]  sample_channel = 0;
   logic [15:0] sample = 0;
   logic [6:0]  reg_addr;
   logic [7:0]  rd_data, rd_data4;
   int          mismatches = 0, checked = 0, cycles = 0;
   always #20 clock = ~clock;
   // Both builds see the same samples and the same host requests.
   alarm_flag_registers alarm_flag_registers_inst (.clock(clock), .arst_n(arst_n),
      .sample_valid(sample_valid), .sample_channel(sample_channel), .sample(sample),
      .high_thresholds({8{16'h8000}}), .low_thresholds({8{16'h1000}}), .hysteresis({8{8'h10}}),
      .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .reg_addr(reg_addr), .rd_data(rd_data),
      .rd_valid(), .rd_hit(rd_hit), .wr_ack(), .alarm(alarm));
   alarm_flag_registers #(.NUM_CHANNELS(4)) alarm_flag_registers_four_inst (.clock(clock),
      .arst_n(arst_n), .sample_valid(sample_valid), .sample_channel(sample_channel),
      .sample(sample), .high_thresholds({8{16'h8000}}), .low_thresholds({8{16'h1000}}),
      .hysteresis({8{8'h10}}), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
      .reg_addr(reg_addr), .rd_data(rd_data4), .rd_valid(), .rd_hit(), .wr_ack(), .alarm());
   alarm_host_model alarm_host_model_inst (.clock(clock), .rd_data(rd_data), .rd_hit(rd_hit),
      .alarm(alarm), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .reg_addr(reg_addr));
   // Compares one value and counts it.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Reads one register and compares it.
   task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       h;
      alarm_host_model_inst.rd(a, d, h);
      chk(d, exp);
   endtask
   // Presents one conversion result, then lets the flags settle.
   task automatic send(input logic [2:0] ch, input logic [15:0] v);
      @(posedge clock);
      #1 sample_channel = ch;
      sample = v;
      sample_valid = 1'b1;
      @(posedge clock);
      #1 sample_valid = 1'b0;
      sample = ~v;
      repeat (3) @(posedge clock);
   endtask
   // Every register reads zero after reset; the small build fills absent bits with ones.
   task automatic t_reset;
      logic [7:0] d;
      logic [6:0] a;
      logic       h;
      for (int i = 0; i < 6; i++) begin
         a = (i == 5) ? 7'h20 : 7'h10 + 7'(i);
         alarm_host_model_inst.rd(a, d, h);
         chk(d, 8'h00);
         chk({7'h0, h}, {7'h0, i < 5});
         chk(rd_data4, a == 7'h10 ? 8'hF0 : (a == 7'h13 || a == 7'h14) ? 8'hFF : 8'h00);
      end
      $display("test reset done");
   endtask
   // High alarm on channel 1: live flag, hysteresis hold, latch and clear on read.
   task automatic t_high;
      logic ok;
      send(3'd1, 16'h9000);
      alarm_host_model_inst.wait_alarm(ok);
      chk({7'h0, ok}, 8'h01);
      rdc(7'h12, 8'h10);
      rdc(7'h10, 8'h02);
      rdc(7'h11, 8'h10);
      rdc(7'h11, 8'h10);
      send(3'd1, 16'h7FF8);
      rdc(7'h12, 8'h10);
      send(3'd1, 16'h4000);
      rdc(7'h12, 8'h00);
      rdc(7'h11, 8'h10);
      rdc(7'h11, 8'h00);
      $display("test high done");
   endtask
   // Low alarm on channel 6: upper registers, ignored writes, absent channel in small build.
   task automatic t_low;
      send(3'd6, 16'h0800);
      rdc(7'h14, 8'h08);
      chk(rd_data4, 8'hFF);
      alarm_host_model_inst.wr(7'h13);
      rdc(7'h13, 8'h08);
      send(3'd6, 16'h4000);
      rdc(7'h13, 8'h08);
      rdc(7'h13, 8'h00);
      rdc(7'h10, 8'h00);
      chk(rd_data4, 8'hF0);
      $display("test low done");
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_sim;
      end
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clock);
      t_reset;
      t_high;
      t_low;
      end_sim;
   end
endmodule
